// [design/mps_pkg.sv]
// constants, state enum and code-table decode for the multiphase pwm sequencer
// assumes one mclk domain; pins are synchronised inside the top module
// Function
// - four phases by default; three if d grounded; two if c and d grounded.
// - on enable weakly drive c and d, compare each; low reading disables phase.
// - detection lasts two oscillator cycles; a and b held inactive meanwhile.
// - after detection active phases switch full swing; grounded ones stay off.
// - each phase output runs independently; near full duty and overlap allowed.
// - per-phase frequency is oscillator divided by active phase count.
// - code select high decodes five code bits with the 5-bit table.
// - code select low becomes the sixth, least significant code bit.
// - 5-bit all-ones is no processor; others 1.100 V to 1.850 V, 25 mV steps.
// - no-processor code enters no-processor state with all phase outputs off.
// - 6-bit 11111x is no processor; others 0.8375 V to 1.6000 V, 12.5 mV.
// - while enable is low all phase outputs stay disabled.
package mps_pkg;
   localparam int MPS_OSC_DIV_DEF = 40;
   localparam int MPS_ON_W_DEF = 8;
   localparam int MPS_NUM_PH = 4;
   localparam logic [1:0] MPS_DET_TICKS = 2'h2;
   localparam logic [2:0] MPS_NPH_MIN = 3'h2;
   localparam int MPS_VREF_W = 15;
   // voltages in units of 0.1 mV
   localparam int MPS_VREF5_TOP = 18500;
   localparam int MPS_STEP5 = 250;
   localparam int MPS_VREF6_BASE = 8375;
   localparam int MPS_STEP6 = 125;
   localparam int MPS_V6_PIVOT = 20;
   localparam int MPS_V6_WRAP = 82;
   localparam logic [MPS_VREF_W-1:0] MPS_VREF_RST = 15'h0000;

   typedef enum logic [1:0] {MPS_IDLE, MPS_DETECT, MPS_RUN} mps_state_e;

   function automatic logic [MPS_VREF_W-1:0] mps_vid_decode(input logic mode6, input logic [4:0] vid,
                                                           input logic sel);
      int v;
      int r;
      v = int'({vid, sel});
      if (&vid) begin
         r = 0;
      end else if (!mode6) begin
         r = MPS_VREF5_TOP - MPS_STEP5 * int'(vid);
      end else if (v <= MPS_V6_PIVOT) begin
         r = MPS_VREF6_BASE + MPS_STEP6 * (MPS_V6_PIVOT - v);
      end else begin
         r = MPS_VREF6_BASE + MPS_STEP6 * (MPS_V6_WRAP - v);
      end
      return MPS_VREF_W'(r);
   endfunction
endpackage

// [design/mps_chan_if.sv]
// carrier between the sequencer and one phase channel
// assumes both ends on mclk
interface mps_chan_if #(parameter int ON_W = 8) ();
   logic start;
   logic allow;
   logic [ON_W-1:0] on_time;
   logic out;
   modport ctrl (output start, output allow, output on_time, input out);
   modport chan (input start, input allow, input on_time, output out);
endinterface

// [design/mps_phase_chan.sv]
// one phase output: on-time counter started by the sequencer
// assumes start and on_time come from logic on mclk
module mps_phase_chan #(
   parameter int ON_W = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   mps_chan_if.chan ch
);
   import mps_pkg::*;

   typedef struct packed {
      logic [ON_W-1:0] cnt;
      logic out;
   } mps_chan_s;

   mps_chan_s s_ff;
   mps_chan_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (!ch.allow) begin
         nxt_s = '0;
      end else if (ch.start) begin
         // reload even while on: lets duty approach full on
         nxt_s.cnt = ch.on_time;
         nxt_s.out = (ch.on_time != '0);
      end else if (s_ff.cnt != '0) begin
         nxt_s.cnt = s_ff.cnt - 1'b1;
         nxt_s.out = (s_ff.cnt > ON_W'(1));
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else if (clk_en) begin
         s_ff <= nxt_s;
      end
   end

   assign ch.out = s_ff.out;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_start_raises_out: assert property (clk_en && ch.allow && ch.start && ch.on_time != '0 |=> s_ff.out)
      else $error("phase output did not rise after start");
   a_blocked_stays_off: assert property (clk_en && !ch.allow |=> !s_ff.out)
      else $error("phase output high while not allowed");
endmodule

// [design/mps_seq.sv]
// multiphase pwm sequencer top: phase detection, code decode, round-robin phase starts
// assumes pins (enable, code bits, detect comparators) are asynchronous; on_time is on mclk
module mps_seq #(
   parameter int OSC_DIV = mps_pkg::MPS_OSC_DIV_DEF,
   parameter int ON_W = mps_pkg::MPS_ON_W_DEF
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic en_pin,
   input wire logic code_table_select,
   input wire logic volt_code_bit0,
   input wire logic volt_code_bit1,
   input wire logic volt_code_bit2,
   input wire logic volt_code_bit3,
   input wire logic volt_code_bit4,
   input wire logic phase_c_sense,
   input wire logic phase_d_sense,
   input wire logic [mps_pkg::MPS_NUM_PH-1:0][ON_W-1:0] on_time,
   output logic phase_out_a,
   output logic phase_out_b,
   output logic phase_out_c,
   output logic phase_out_d,
   output logic phase_det_drive,
   output logic [2:0] active_phases,
   output logic code_mode_6bit,
   output logic no_cpu,
   output logic running,
   output logic [mps_pkg::MPS_VREF_W-1:0] vref_code
);
   import mps_pkg::*;

   localparam int OSC_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
   localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

   typedef struct packed {
      mps_state_e st;
      logic [1:0] en_s;
      logic [1:0] sel_s;
      logic [1:0] c_s;
      logic [1:0] d_s;
      logic [4:0] vid_s0;
      logic [4:0] vid_s1;
      logic [OSC_W-1:0] osc;
      logic [1:0] det_cnt;
      logic [1:0] rr;
      logic [2:0] nph;
      logic c_en;
      logic d_en;
      logic mode6;
      logic det_drive;
      logic nocpu;
      logic [MPS_VREF_W-1:0] vref;
      logic run;
   } mps_seq_s;

   mps_seq_s s_ff;
   mps_seq_s nxt_s;
   logic tick;
   logic [MPS_NUM_PH-1:0] ph_en;
   logic [MPS_NUM_PH-1:0] ph_out;

   assign tick = (s_ff.osc == OSC_LAST);

   always_comb begin
      nxt_s = s_ff;
      nxt_s.en_s = {s_ff.en_s[0], en_pin};
      nxt_s.sel_s = {s_ff.sel_s[0], code_table_select};
      nxt_s.c_s = {s_ff.c_s[0], phase_c_sense};
      nxt_s.d_s = {s_ff.d_s[0], phase_d_sense};
      nxt_s.vid_s0 = {volt_code_bit4, volt_code_bit3, volt_code_bit2, volt_code_bit1, volt_code_bit0};
      nxt_s.vid_s1 = s_ff.vid_s0;
      nxt_s.osc = tick ? '0 : s_ff.osc + 1'b1;
      unique case (s_ff.st)
         MPS_IDLE: begin
            // osc parked at zero: first tick comes OSC_DIV cycles after entry
            nxt_s.osc = '0;
            nxt_s.det_cnt = '0;
            nxt_s.rr = '0;
            if (s_ff.en_s[1]) begin
               nxt_s.st = MPS_DETECT;
               nxt_s.det_drive = 1'b1;
            end
         end
         MPS_DETECT: begin
            // a and b stay blocked here
            if (tick) begin
               nxt_s.det_cnt = s_ff.det_cnt + 1'b1;
               if (s_ff.det_cnt == MPS_DET_TICKS - 2'h1) begin
                  nxt_s.st = MPS_RUN;
                  nxt_s.det_drive = 1'b0;
                  // latch detection and mode until disable
                  nxt_s.c_en = s_ff.c_s[1];
                  nxt_s.d_en = s_ff.c_s[1] & s_ff.d_s[1];
                  nxt_s.nph = MPS_NPH_MIN + 3'(s_ff.c_s[1]) + 3'(s_ff.c_s[1] & s_ff.d_s[1]);
                  nxt_s.mode6 = ~s_ff.sel_s[1];
               end
            end
         end
         MPS_RUN: begin
            if (tick) begin
               // one phase start per oscillator period
               nxt_s.rr = (s_ff.rr == 2'(s_ff.nph - 3'h1)) ? 2'h0 : s_ff.rr + 2'h1;
            end
         end
      endcase
      if (s_ff.st == MPS_RUN) begin
         nxt_s.nocpu = &s_ff.vid_s1;
         nxt_s.vref = mps_vid_decode(s_ff.mode6, s_ff.vid_s1, s_ff.sel_s[1]);
      end
      if (!s_ff.en_s[1]) begin
         // disable drops state, drive and latched results back to reset values
         nxt_s.st = MPS_IDLE;
         nxt_s.det_drive = 1'b0;
         nxt_s.c_en = 1'b0;
         nxt_s.d_en = 1'b0;
         nxt_s.nph = '0;
         nxt_s.mode6 = 1'b0;
         nxt_s.nocpu = 1'b0;
         nxt_s.vref = MPS_VREF_RST;
      end
      // running leaves from its own flop, in step with the state
      nxt_s.run = (nxt_s.st == MPS_RUN);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else if (clk_en) begin
         s_ff <= nxt_s;
      end
   end

   assign ph_en = {s_ff.d_en, s_ff.c_en, 2'h3};

   for (genvar i = 0; i < MPS_NUM_PH; i++) begin : g_ch
      mps_chan_if #(.ON_W(ON_W)) chif ();
      // grounded, disabled or no-processor phases kept off
      // synced enable cuts allow one edge before the state leaves run
      assign chif.allow = (s_ff.st == MPS_RUN) && ph_en[i] && !s_ff.nocpu && s_ff.en_s[1];
      assign chif.start = tick && (s_ff.rr == 2'(i));
      assign chif.on_time = on_time[i];
      assign ph_out[i] = chif.out;
      mps_phase_chan #(.ON_W(ON_W)) u_ch (
         .mclk(mclk),
         .rst(rst),
         .clk_en(clk_en),
         .ch(chif.chan)
      );
   end

   assign phase_out_a = ph_out[0];
   assign phase_out_b = ph_out[1];
   assign phase_out_c = ph_out[2];
   assign phase_out_d = ph_out[3];
   assign phase_det_drive = s_ff.det_drive;
   assign active_phases = s_ff.nph;
   assign code_mode_6bit = s_ff.mode6;
   assign no_cpu = s_ff.nocpu;
   assign running = s_ff.run;
   assign vref_code = s_ff.vref;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_disabled_all_off: assert property (s_ff.st == MPS_IDLE && $past(s_ff.st) == MPS_IDLE |-> ph_out == '0)
      else $error("phase output active while disabled");
   a_detect_ab_low: assert property (s_ff.st == MPS_DETECT && $past(s_ff.st) == MPS_DETECT
                                     |-> ph_out[1:0] == 2'h0)
      else $error("phase a or b active during detection");
   a_detect_drive_on: assert property (s_ff.st == MPS_DETECT |-> s_ff.det_drive)
      else $error("detect drive missing during detection");
   a_phase_count: assert property (s_ff.st == MPS_RUN |-> s_ff.nph == 3'h2 + 3'(s_ff.c_en) + 3'(s_ff.d_en))
      else $error("active phase count inconsistent");
   a_grounded_stay_off: assert property (s_ff.st == MPS_RUN && $past(s_ff.st) == MPS_RUN && !s_ff.d_en
                                         |-> !ph_out[3])
      else $error("grounded phase switching");
   a_grounded_c_off: assert property (s_ff.st == MPS_RUN && $past(s_ff.st) == MPS_RUN && !s_ff.c_en
                                      |-> !ph_out[2])
      else $error("grounded third phase switching");
   a_round_robin: assert property (clk_en && tick && s_ff.st == MPS_RUN && s_ff.en_s[1]
      |=> s_ff.rr == (($past(s_ff.rr) == 2'($past(s_ff.nph) - 3'h1)) ? 2'h0 : $past(s_ff.rr) + 2'h1))
      else $error("round robin order broken");
   a_nocpu_off: assert property (s_ff.nocpu && $past(s_ff.nocpu) |-> ph_out == '0)
      else $error("phase output active with no processor");
   a_nocpu_vref_zero: assert property (s_ff.nocpu |-> s_ff.vref == '0)
      else $error("target set while no processor");
   a_mode_held: assert property (s_ff.st == MPS_RUN && $past(s_ff.st) == MPS_RUN
                                 |-> $stable(s_ff.mode6) && $stable(s_ff.nph))
      else $error("latched mode changed while running");
   a_vref5_range: assert property (s_ff.st == MPS_RUN && !s_ff.mode6 && !s_ff.nocpu && s_ff.vref != '0
                                   |-> s_ff.vref >= 15'h2af8 && s_ff.vref <= 15'h4844)
      else $error("5-bit target out of range");
   a_vref6_range: assert property (s_ff.st == MPS_RUN && s_ff.mode6 && !s_ff.nocpu && s_ff.vref != '0
                                   |-> s_ff.vref >= 15'h20b7 && s_ff.vref <= 15'h3e80)
      else $error("6-bit target out of range");

   // detection window and the results latched at its end
   a_detect_length: assert property (s_ff.st == MPS_RUN && $past(s_ff.st) == MPS_DETECT
                                     |-> $past(tick) && $past(s_ff.det_cnt) == MPS_DET_TICKS - 2'h1)
      else $error("detection did not last two oscillator cycles");
   a_mode_latched: assert property (s_ff.st == MPS_RUN && $past(s_ff.st) == MPS_DETECT
                                    |-> s_ff.mode6 == !$past(s_ff.sel_s[1]))
      else $error("code mode does not follow select at detection end");
   a_d_needs_c: assert property (s_ff.d_en |-> s_ff.c_en)
      else $error("fourth phase enabled without third");
   a_run_drive_off: assert property (s_ff.st == MPS_RUN |-> !s_ff.det_drive)
      else $error("detect drive left on while running");
   a_idle_drive_off: assert property (s_ff.st == MPS_IDLE |-> !s_ff.det_drive)
      else $error("detect drive on while idle");
   a_idle_nph_clear: assert property (s_ff.st == MPS_IDLE
                                      |-> s_ff.nph == '0 && !s_ff.mode6)
      else $error("latched results kept while disabled");
   a_vref_idle_zero: assert property (s_ff.st != MPS_RUN
                                      |-> s_ff.vref == '0 && !s_ff.nocpu)
      else $error("target or no-processor flag set while not running");

   c_run_four: cover property (s_ff.st == MPS_RUN && s_ff.nph == 3'h4);
   c_run_three: cover property (s_ff.st == MPS_RUN && s_ff.nph == 3'h3);
   c_run_two: cover property (s_ff.st == MPS_RUN && s_ff.nph == 3'h2);
   c_no_cpu: cover property (s_ff.st == MPS_RUN && s_ff.nocpu);
   c_overlap: cover property (ph_out[0] && ph_out[1]);
endmodule

// [tb/mps_drv_model.sv]
// gate driver side: grounded or open phase pins, pulse counts per phase
// assumes phase outputs are registers on mclk
module mps_drv_model (
   input wire logic mclk,
   input wire logic det_drive,
   input wire logic pres_c,
   input wire logic pres_d,
   input wire logic [3:0] pwm,
   input wire logic clr,
   output logic c_sense,
   output logic d_sense,
   output int pulses [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] prev;
   // grounded pin reads below threshold; open pin shows weak level or drive
   assign c_sense = pres_c & (det_drive | pwm[2]);
   assign d_sense = pres_d & (det_drive | pwm[3]);
   always @(posedge mclk) begin
      prev <= pwm;
      for (int i = 0; i < 4; i++) begin
         if (clr) begin
            pulses[i] <= 0;
         end else if (pwm[i] === 1'h1 && prev[i] === 1'h0) begin
            pulses[i] <= pulses[i] + 1;
         end
      end
   end
endmodule

// [tb/mps_seq_tb.sv]
// self-checking bench for mps_seq: detection, code decode, phase timing
// assumes mps_drv_model stands in for the gate drivers
module mps_seq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mps_pkg::*;
   localparam int DIV = 4;
   typedef struct {logic s; logic [4:0] v; logic pc; logic pd; logic [2:0] n; logic [14:0] r;} mps_row_s;
   mps_row_s rows [7] = '{'{1'h1, 5'h1e, 1'h1, 1'h1, 3'h4, 15'h2af8}, '{1'h1, 5'h00, 1'h1, 1'h0, 3'h3, 15'h4844},
      '{1'h1, 5'h1f, 1'h1, 1'h1, 3'h4, 15'h0000}, '{1'h0, 5'h0a, 1'h0, 1'h0, 3'h2, 15'h20b7},
      '{1'h0, 5'h00, 1'h0, 1'h1, 3'h2, 15'h2a7b}, '{1'h0, 5'h1f, 1'h1, 1'h1, 3'h4, 15'h0000},
      '{1'h0, 5'h1e, 1'h1, 1'h0, 3'h3, 15'h2b75}};
   logic mclk = 0, rst = 1, en = 0, sel = 1, pc = 1, pd = 1, clr = 0;
   logic [4:0] vc = 5'h1f;
   logic [3:0][7:0] ont = {4{8'h02}};
   logic [3:0] pwm;
   logic det, c_s, d_s, run, mode, nocpu;
   logic [2:0] nph;
   logic [14:0] vref;
   int pulses [4];
   int miscompares = 0;
   int checks = 0;
   always #12.5 mclk = ~mclk;
   mps_seq #(.OSC_DIV(DIV), .ON_W(8)) uut (.mclk(mclk), .rst(rst), .clk_en(1'h1), .en_pin(en),
      .code_table_select(sel), .volt_code_bit0(vc[0]), .volt_code_bit1(vc[1]), .volt_code_bit2(vc[2]),
      .volt_code_bit3(vc[3]), .volt_code_bit4(vc[4]), .phase_c_sense(c_s), .phase_d_sense(d_s), .on_time(ont),
      .phase_out_a(pwm[0]), .phase_out_b(pwm[1]), .phase_out_c(pwm[2]), .phase_out_d(pwm[3]),
      .phase_det_drive(det), .active_phases(nph), .code_mode_6bit(mode), .no_cpu(nocpu), .running(run),
      .vref_code(vref));
   mps_drv_model drv (.mclk(mclk), .det_drive(det), .pres_c(pc), .pres_d(pd), .pwm(pwm), .clr(clr),
      .c_sense(c_s), .d_sense(d_s), .pulses(pulses));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic start(input mps_row_s r);
      int k;
      logic seen;
      k = 0;
      seen = 0;
      @(posedge mclk);
      en <= 0;
      cyc(6);
      @(posedge mclk);
      {sel, vc, pc, pd} <= {r.s, r.v, r.pc, r.pd};
      en <= 1;
      while (run !== 1'h1 && k < 40) begin
         @(negedge mclk);
         k++;
         if (det === 1'h1) begin
            seen = 1;
            cmp(16'(pwm[1:0]), 16'h0);
         end
      end
      cmp(16'(seen), 16'h1);
      cmp(16'(nph), 16'(r.n));
      cmp(16'(mode), 16'(!r.s));
      cyc(4);
      cmp(16'(vref), 16'(r.r));
      cmp(16'(nocpu), 16'(r.r == 0));
   endtask
   task automatic rise(input int i, inout int k);
      while (pwm[i] !== 1'h0 && k < 99) begin
         @(negedge mclk);
         k++;
      end
      while (pwm[i] !== 1'h1 && k < 99) begin
         @(negedge mclk);
         k++;
      end
   endtask
   task automatic gap(input int i, input int j, input int exp);
      int k;
      k = 0;
      rise(i, k);
      k = 0;
      rise(j, k);
      cmp(16'(k), 16'(exp));
   endtask
   task automatic count(input int n);
      @(posedge mclk);
      clr <= 1;
      @(posedge mclk);
      clr <= 0;
      cyc(n);
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      finish_test();
   end
   initial begin
      logic ovl;
      ovl = 0;
      cyc(19);
      cmp(16'({pwm, run, det, nph}), 16'h0);
      @(posedge mclk);
      rst <= 0;
      foreach (rows[i]) begin
         start(rows[i]);
         count(64);
         for (int p = 0; p < 4; p++) begin
            cmp(16'(pulses[p] > 0), 16'(p < rows[i].n && rows[i].r != 0));
         end
         if (rows[i].r != 0) begin
            gap(0, 0, DIV * rows[i].n);
            gap(0, 1, DIV);
         end
      end
      start(rows[3]);
      @(posedge mclk);
      sel <= 1;
      pc <= 1;
      cyc(5);
      cmp(16'(vref), 16'h3e80);
      cmp(16'({mode, nph}), 16'h000a);
      start(rows[0]);
      @(posedge mclk);
      ont <= {4{8'h0c}};
      repeat (40) begin
         @(negedge mclk);
         ovl = ovl | (pwm[0] & pwm[1]);
      end
      cmp(16'(ovl), 16'h1);
      @(posedge mclk);
      rst <= 1;
      cyc(3);
      cmp(16'({pwm, run, det, nph, nocpu, mode}), 16'h0);
      @(posedge mclk);
      rst <= 0;
      cyc(16);
      cmp(16'({run, nph}), 16'h000c);
      @(posedge mclk);
      en <= 0;
      cyc(4);
      cmp(16'({pwm, run}), 16'h0);
      count(3 * DIV);
      cmp(16'(pulses[0] + pulses[1] + pulses[2] + pulses[3]), 16'h0);
      finish_test();
   end
endmodule
